/* src/meb_bus_master.sv */
// External multiplexed address/data bus master with ready and hold.
//
// Functional notes
// - Accesses happen only while strobe is low.
// - Width select low gives 16 bits, high 8.
// - Bus clock is input clock divided by two.
// - Ready low stretches the current access.
// - Release request low holds device in hold.
// - Acknowledge output shows the hold state.
// - Read/write high on reads, low on writes.
// - Upper byte enable low on odd addresses.
// - Latch strobe marks address on shared lines.
// - 16-bit: middle lines carry address then data.
// - 8-bit: middle lines carry address only.
// - Upper lines carry address then data of even addresses, or every byte in 8-bit mode.
`timescale 1ns/1ps

module meb_bus_master
(
    input  wire logic            i_clk,
    input  wire logic            i_reset_n,
    input  wire logic            i_ce,
    input  wire logic            i_req_valid,
    input  wire meb_pkg::meb_req_s i_req,
    output logic                 o_req_ready,
    output logic                 o_done,
    output logic [15:0]          o_rdata,
    input  wire logic            i_byte_sel,
    input  wire logic            i_ready,
    input  wire logic            i_hold_req_n,
    output logic                 o_bus_clk,
    output logic                 o_bus_release_ack,
    output logic                 o_strobe_n,
    output logic                 o_rd_wr,
    output logic                 o_upper_byte_en_n,
    output logic                 o_addr_latch,
    output logic                 o_ctl_oe,
    output logic [7:0]           o_addr_lo,
    input  wire logic [7:0]      i_mid_in,
    output logic [7:0]           o_mid_out,
    output logic                 o_mid_oe,
    input  wire logic [7:0]      i_hi_in,
    output logic [7:0]           o_hi_out,
    output logic                 o_hi_oe
);
    import meb_pkg::*;

    // ------------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_sync_reg <= 2'h0;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    logic ready_lvl;
    logic hold_req_n_lvl;
    logic byte_sel_lvl;

    meb_pin_sync #(.RST_VAL(READY_RST)) u_sync_ready
    (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_ce    (i_ce),
        .i_pin   (i_ready),
        .o_level (ready_lvl)
    );

    meb_pin_sync #(.RST_VAL(HOLD_REQ_RST)) u_sync_hold
    (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_ce    (i_ce),
        .i_pin   (i_hold_req_n),
        .o_level (hold_req_n_lvl)
    );

    meb_pin_sync #(.RST_VAL(BYTE_SEL_RST)) u_sync_byte
    (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_ce    (i_ce),
        .i_pin   (i_byte_sel),
        .o_level (byte_sel_lvl)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    meb_state_e state_reg;
    meb_state_e state_next;
    meb_req_s   cur_reg;
    meb_pins_s  pins_reg;
    meb_pins_s  pins_next;
    logic       pend_reg;
    logic       second_reg;
    logic       bus_clk_reg;
    logic       req_ready_reg;
    logic       done_reg;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    wire        tick      = bus_clk_reg;
    wire        take_req  = req_ready_reg && i_req_valid;
    wire [23:0] addr_now  = second_reg ? cur_reg.addr + 24'h000001
                                       : cur_reg.addr;
    wire        bus8      = byte_sel_lvl;
    wire        wide      = !bus8 && cur_reg.word && !cur_reg.addr[0];
    wire        split     = cur_reg.word && !wide;
    wire [7:0]  bdat      = second_reg ? cur_reg.wdata[15:8]
                                       : cur_reg.wdata[7:0];
    wire        odd_lane  = !bus8 && addr_now[0];
    wire [7:0]  lane_in   = odd_lane ? i_mid_in : i_hi_in;
    wire        data_end  = (state_reg == ST_DATA) && tick && ready_lvl;
    wire        last_part = !split || second_reg;
    wire        in_addr   = (state_reg == ST_ADDR) ||
                            (state_reg == ST_LATCH);
    wire        in_data   = (state_reg == ST_DATA);
    wire        in_hold   = (state_reg == ST_HOLD);

    // ------------------------------------------------------------------
    // Sequencer: state moves at most once per bus clock period
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        if (tick)
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (!hold_req_n_lvl)
                    begin
                        state_next = ST_HOLD;
                    end
                    else if (pend_reg)
                    begin
                        state_next = ST_ADDR;
                    end
                end
                ST_ADDR:  state_next = ST_LATCH;
                ST_LATCH: state_next = ST_DATA;
                ST_DATA:
                begin
                    if (ready_lvl)
                    begin
                        state_next = last_part ? ST_IDLE : ST_ADDR;
                    end
                end
                ST_HOLD:
                begin
                    if (hold_req_n_lvl)
                    begin
                        state_next = ST_IDLE;
                    end
                end
                default: state_next = ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pin values
    // ------------------------------------------------------------------
    always_comb
    begin
        pins_next                 = PINS_RST;
        pins_next.addr_lo         = addr_now[ADDR_LO_MSB:0];
        pins_next.strobe_n        = !in_data;
        pins_next.rd_wr           = !cur_reg.write;
        pins_next.upper_byte_en_n = !(addr_now[0] || wide);
        pins_next.addr_latch      = (state_reg == ST_ADDR);
        pins_next.ctl_oe          = !in_hold;
        pins_next.bus_release_ack = in_hold;
        if (in_addr)
        begin
            pins_next.mid_out = addr_now[ADDR_MID_MSB:ADDR_MID_LSB];
            pins_next.hi_out  = addr_now[ADDR_HI_MSB:ADDR_HI_LSB];
            pins_next.mid_oe  = 1'b1;
            pins_next.hi_oe   = 1'b1;
        end
        else if (in_data)
        begin
            if (bus8)
            begin
                pins_next.mid_out = addr_now[ADDR_MID_MSB:ADDR_MID_LSB];
                pins_next.mid_oe  = 1'b1;
            end
            else
            begin
                pins_next.mid_out = wide ? cur_reg.wdata[15:8] : bdat;
                pins_next.mid_oe  = cur_reg.write && (wide || odd_lane);
            end
            pins_next.hi_out = wide ? cur_reg.wdata[7:0] : bdat;
            pins_next.hi_oe  = cur_reg.write && !odd_lane;
        end
        else if (state_reg == ST_IDLE)
        begin
            pins_next.mid_out = addr_now[ADDR_MID_MSB:ADDR_MID_LSB];
            pins_next.mid_oe  = bus8;
        end
    end

    // ------------------------------------------------------------------
    // Read data assembly
    // ------------------------------------------------------------------
    always_comb
    begin
        rdata_next = rdata_reg;
        if (data_end && !cur_reg.write)
        begin
            if (wide)
            begin
                rdata_next = {i_mid_in, i_hi_in};
            end
            else if (second_reg)
            begin
                rdata_next[15:8] = lane_in;
            end
            else
            begin
                rdata_next = {8'h00, lane_in};
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg     <= ST_IDLE;
            cur_reg       <= REQ_RST;
            pins_reg      <= PINS_RST;
            pend_reg      <= 1'b0;
            second_reg    <= 1'b0;
            bus_clk_reg   <= 1'b0;
            req_ready_reg <= 1'b0;
            done_reg      <= 1'b0;
            rdata_reg     <= 16'h0000;
        end
        else if (i_ce)
        begin
            bus_clk_reg <= !bus_clk_reg;
            state_reg   <= state_next;
            pins_reg    <= pins_next;
            rdata_reg   <= rdata_next;
            done_reg    <= data_end && last_part;
            if (take_req)
            begin
                cur_reg  <= i_req;
                pend_reg <= 1'b1;
            end
            else if (data_end && last_part)
            begin
                pend_reg <= 1'b0;
            end
            if (data_end)
            begin
                second_reg <= split && !second_reg;
            end
            req_ready_reg <= !pend_reg && !take_req &&
                             !(data_end && last_part);
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_req_ready       = req_ready_reg;
    assign o_done            = done_reg;
    assign o_rdata           = rdata_reg;
    assign o_bus_clk         = bus_clk_reg;
    assign o_bus_release_ack = pins_reg.bus_release_ack;
    assign o_strobe_n        = pins_reg.strobe_n;
    assign o_rd_wr           = pins_reg.rd_wr;
    assign o_upper_byte_en_n = pins_reg.upper_byte_en_n;
    assign o_addr_latch      = pins_reg.addr_latch;
    assign o_ctl_oe          = pins_reg.ctl_oe;
    assign o_addr_lo         = pins_reg.addr_lo;
    assign o_mid_out         = pins_reg.mid_out;
    assign o_mid_oe          = pins_reg.mid_oe;
    assign o_hi_out          = pins_reg.hi_out;
    assign o_hi_oe           = pins_reg.hi_oe;

endmodule

/* src/meb_pkg.sv */
// Package of constants and types for the multiplexed external bus master.
package meb_pkg;

    // ------------------------------------------------------------------
    // Clocking and reset constants
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned BUS_CLK_DIV   = 2;
    localparam int unsigned PIN_SYNC_LEN  = 3;
    localparam int unsigned RST_SYNC_LEN  = 2;

    // ------------------------------------------------------------------
    // Field positions of the 24-bit address
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W      = 24;
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned ADDR_LO_MSB = 7;
    localparam int unsigned ADDR_MID_LSB = 8;
    localparam int unsigned ADDR_MID_MSB = 15;
    localparam int unsigned ADDR_HI_LSB = 16;
    localparam int unsigned ADDR_HI_MSB = 23;

    // ------------------------------------------------------------------
    // Bus sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_LATCH = 3'b010,
        ST_DATA  = 3'b011,
        ST_HOLD  = 3'b100
    } meb_state_e;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic        write;
        logic        word;
    } meb_req_s;

    typedef struct packed
    {
        logic       strobe_n;
        logic       rd_wr;
        logic       upper_byte_en_n;
        logic       addr_latch;
        logic [7:0] addr_lo;
        logic [7:0] mid_out;
        logic       mid_oe;
        logic [7:0] hi_out;
        logic       hi_oe;
        logic       ctl_oe;
        logic       bus_release_ack;
    } meb_pins_s;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam meb_req_s REQ_RST = '{addr: 24'h000000, wdata: 16'h0000,
                                     write: 1'b0, word: 1'b0};
    localparam meb_pins_s PINS_RST = '{strobe_n: 1'b1, rd_wr: 1'b1,
        upper_byte_en_n: 1'b1, addr_latch: 1'b0, addr_lo: 8'h00,
        mid_out: 8'h00, mid_oe: 1'b0, hi_out: 8'h00, hi_oe: 1'b0,
        ctl_oe: 1'b1, bus_release_ack: 1'b0};
    localparam logic READY_RST    = 1'b1;
    localparam logic HOLD_REQ_RST = 1'b1;
    localparam logic BYTE_SEL_RST = 1'b0;

endpackage

/* src/meb_pin_sync.sv */
// Three-stage synchroniser with agreement filter for pin inputs.
`timescale 1ns/1ps

module meb_pin_sync
#(
    parameter logic RST_VAL = 1'b0
)
(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    input  wire logic i_pin,
    output logic      o_level
);
    import meb_pkg::*;

    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic level_reg;
    logic agree;

    // A change counts only once the second and third stages agree.
    assign agree   = (stage2_reg == stage3_reg);
    assign o_level = level_reg;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            stage1_reg <= RST_VAL;
            stage2_reg <= RST_VAL;
            stage3_reg <= RST_VAL;
            level_reg  <= RST_VAL;
        end
        else if (i_ce)
        begin
            stage1_reg <= i_pin;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            if (agree)
            begin
                level_reg <= stage3_reg;
            end
        end
    end

endmodule

/* verif/meb_bus_master_asserts.sv */
// Port-level concurrent checks for the external bus master.
`timescale 1ns/1ps
module meb_bus_master_asserts
    import meb_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_reset_n,
    input wire logic              i_ce,
    input wire logic              i_req_valid,
    input wire meb_pkg::meb_req_s i_req,
    input wire logic              o_req_ready,
    input wire logic              i_byte_sel,
    input wire logic              o_bus_clk,
    input wire logic              o_bus_release_ack,
    input wire logic              o_strobe_n,
    input wire logic              o_rd_wr,
    input wire logic              o_upper_byte_en_n,
    input wire logic              o_addr_latch,
    input wire logic              o_ctl_oe,
    input wire logic [7:0]        o_addr_lo,
    input wire logic [7:0]        o_mid_out,
    input wire logic              o_mid_oe,
    input wire logic [7:0]        o_hi_out,
    input wire logic              o_hi_oe
);
    logic [2:0] run_reg;
    logic [5:0] low_reg;
    meb_req_s   cap_reg;

    // Edges since reset, strobe-low length and the request in flight.
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            run_reg <= 3'h0;
            low_reg <= 6'h00;
            cap_reg <= REQ_RST;
        end
        else
        begin
            run_reg <= (run_reg == 3'h4) ? run_reg : run_reg + 3'h1;
            low_reg <= o_strobe_n ? 6'h00 : low_reg + 6'h01;
            if (i_req_valid && o_req_ready)
                cap_reg <= i_req;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    property p_ale;
        $fell(o_strobe_n) |-> $past(o_addr_latch, 3) && !$past(o_addr_latch);
    endproperty
    a_ale: assert property (p_ale) else $error("latch order");
    property p_bclk;
        run_reg == 3'h4 && $past(i_ce) |-> o_bus_clk != $past(o_bus_clk);
    endproperty
    a_bclk: assert property (p_bclk) else $error("bus clock");
    property p_freeze;
        run_reg == 3'h4 && !$past(i_ce) |->
            $stable(o_bus_clk) && $stable(o_strobe_n);
    endproperty
    a_freeze: assert property (p_freeze) else $error("freeze");
    property p_len;
        $rose(o_strobe_n) |-> low_reg >= 6'h02 && !low_reg[0];
    endproperty
    a_len: assert property (p_len) else $error("strobe length");
    property p_hold;
        o_bus_release_ack |-> o_strobe_n && !o_ctl_oe && !o_mid_oe && !o_hi_oe;
    endproperty
    a_hold: assert property (p_hold) else $error("hold pins");
    property p_ube;
        $fell(o_strobe_n) && o_addr_lo[0] |-> !o_upper_byte_en_n;
    endproperty
    a_ube: assert property (p_ube) else $error("byte enable");
    property p_wword;
        !o_strobe_n && !o_rd_wr && !i_byte_sel && cap_reg.word
            && !cap_reg.addr[0] |-> o_mid_oe && o_hi_oe
            && {o_mid_out, o_hi_out} == cap_reg.wdata;
    endproperty
    a_wword: assert property (p_wword) else $error("write data");
    property p_narrow;
        !o_strobe_n && i_byte_sel |-> o_mid_oe && $stable(o_mid_out);
    endproperty
    a_narrow: assert property (p_narrow) else $error("mid lines");
    property p_ahi;
        o_addr_latch |-> o_hi_oe && o_hi_out == cap_reg.addr[23:16];
    endproperty
    a_ahi: assert property (p_ahi) else $error("upper address");
endmodule

bind meb_bus_master meb_bus_master_asserts chk_u
(
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .i_byte_sel(i_byte_sel),
    .o_bus_clk(o_bus_clk), .o_bus_release_ack(o_bus_release_ack),
    .o_strobe_n(o_strobe_n), .o_rd_wr(o_rd_wr), .o_ctl_oe(o_ctl_oe),
    .o_upper_byte_en_n(o_upper_byte_en_n), .o_addr_latch(o_addr_latch),
    .o_addr_lo(o_addr_lo), .o_mid_out(o_mid_out), .o_mid_oe(o_mid_oe),
    .o_hi_out(o_hi_out), .o_hi_oe(o_hi_oe), .i_ce(i_ce)
);

/* verif/meb_ext_mem.sv */
// Memory model on the far side of the multiplexed external bus.
`timescale 1ns/1ps
module meb_ext_mem
(
    input  wire logic       i_clk,
    input  wire logic       i_byte_sel,
    input  wire logic       i_strobe_n,
    input  wire logic       i_rd_wr,
    input  wire logic       i_upper_byte_en_n,
    input  wire logic       i_addr_latch,
    input  wire logic [7:0] i_addr_lo,
    input  wire logic [7:0] i_mid_out,
    input  wire logic       i_mid_oe,
    input  wire logic [7:0] i_hi_out,
    input  wire logic       i_hi_oe,
    output logic [7:0]      o_mid_in,
    output logic [7:0]      o_hi_in
);
    logic [7:0] mem [256];
    logic [7:0] adr_reg;
    logic [7:0] junk_reg;
    logic [7:0] ev_w;
    logic       rd_w;
    logic       wr_w;

    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'hA5;
        junk_reg = 8'h3C;
    end

    // Undriven lines show a pattern that changes every cycle.
    assign ev_w = {adr_reg[7:1], 1'b0};
    assign rd_w = !i_strobe_n && i_rd_wr;
    assign wr_w = !i_strobe_n && !i_rd_wr;
    assign o_hi_in = !rd_w ? junk_reg
                   : (i_byte_sel ? mem[adr_reg] : mem[ev_w]);
    assign o_mid_in = (rd_w && !i_byte_sel) ? mem[ev_w | 8'h01]
                    : ~junk_reg;

    always @(posedge i_clk)
    begin
        junk_reg <= junk_reg + 8'h5B;
        if (i_addr_latch)
            adr_reg <= i_addr_lo;
        if (wr_w && i_hi_oe && (i_byte_sel || !adr_reg[0]))
            mem[i_byte_sel ? adr_reg : ev_w] <= i_hi_out;
        if (wr_w && i_mid_oe && !i_byte_sel && !i_upper_byte_en_n)
            mem[ev_w | 8'h01] <= i_mid_out;
    end
endmodule

/* verif/testbench.sv */
// Self-checking testbench for the external bus master.
`timescale 1ns/1ps
module testbench;
    import meb_pkg::*;

    logic        clk, rst_n, vld, req_rdy, done, bsel, rdy, hold_n, ce;
    logic        bclk, ack, stb_n, rw, ube_n, ale, ctl_oe, mid_oe, hi_oe;
    meb_req_s    req;
    logic [15:0] rdata;
    logic [7:0]  alo, mid_in, mid_out, hi_in, hi_out;
    logic [7:0]  shadow [256];
    logic [31:0] r, r2;
    integer      seed;
    int          n_mismatch, cmp_count, lo_cnt;

    meb_bus_master dut_u
    (
        .i_clk(clk), .i_reset_n(rst_n), .i_ce(ce), .i_req_valid(vld),
        .i_req(req), .o_req_ready(req_rdy), .o_done(done), .o_rdata(rdata),
        .i_byte_sel(bsel), .i_ready(rdy), .i_hold_req_n(hold_n),
        .o_bus_clk(bclk), .o_bus_release_ack(ack), .o_strobe_n(stb_n),
        .o_rd_wr(rw), .o_upper_byte_en_n(ube_n), .o_addr_latch(ale),
        .o_ctl_oe(ctl_oe), .o_addr_lo(alo), .i_mid_in(mid_in),
        .o_mid_out(mid_out), .o_mid_oe(mid_oe), .i_hi_in(hi_in),
        .o_hi_out(hi_out), .o_hi_oe(hi_oe)
    );
    meb_ext_mem mem_u
    (
        .i_clk(clk), .i_byte_sel(bsel), .i_strobe_n(stb_n), .i_rd_wr(rw),
        .i_upper_byte_en_n(ube_n), .i_addr_latch(ale), .i_addr_lo(alo),
        .i_mid_out(mid_out), .i_mid_oe(mid_oe), .i_hi_out(hi_out),
        .i_hi_oe(hi_oe), .o_mid_in(mid_in), .o_hi_in(hi_in)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string nm, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task end_sim;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic logic [15:0] exp_rd(input logic [7:0] a, input logic w);
        return {w ? shadow[a + 8'h01] : 8'h00, shadow[a]};
    endfunction

    // One access; a stalled one holds ready low for its first 12 cycles.
    task automatic access(input logic [23:0] a, input logic wr, w,
                          input logic [15:0] wd, input logic stall);
        int t;
        logic [15:0] m;
        m = w ? 16'hFFFF : 16'h00FF;
        t = 0;
        @(negedge clk);
        while (!req_rdy && t < 100)
        begin
            @(negedge clk);
            t++;
        end
        vld = 1'b1;
        req = '{addr: a, wdata: wd, write: wr, word: w};
        @(negedge clk);
        vld = 1'b0;
        rdy = !stall;
        lo_cnt = 0;
        t = 0;
        while (done !== 1'b1 && t < 200)
        begin
            @(negedge clk);
            lo_cnt += int'(stb_n === 1'b0);
            t++;
            if (t == 12)
                rdy = 1'b1;
        end
        check("done", 16'(done), 16'h0001);
        if (stall)
            check("stretch", 16'(lo_cnt > 2), 16'h0001);
        if (wr)
        begin
            shadow[a[7:0]] = wd[7:0];
            if (w)
                shadow[a[7:0] + 8'h01] = wd[15:8];
        end
        else
            check("rdata", rdata & m, exp_rd(a[7:0], w) & m);
    endtask

    task automatic wait_ack(input logic v);
        for (int t = 0; t < 40 && ack !== v; t++)
            @(negedge clk);
    endtask

    initial
    begin
        seed = 32'h34b203ce;
        {rst_n, vld, bsel} = 3'b000;
        {rdy, hold_n, ce} = 3'b111;
        req = REQ_RST;
        n_mismatch = 0;
        cmp_count = 0;
        for (int i = 0; i < 256; i++)
            shadow[i] = 8'(i) ^ 8'hA5;
        repeat (16) @(negedge clk);
        check("reset", 16'({ack, stb_n, bclk, ctl_oe}), 16'h0005);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        r = 32'(bclk);
        ce = 1'b0;
        repeat (5) @(negedge clk);
        check("freeze", 16'(bclk), 16'(r[0]));
        ce = 1'b1;
        @(negedge clk);
        check("resume", 16'(bclk), 16'(!r[0]));
        for (int md = 0; md < 2; md++)
        begin
            bsel = md[0];
            repeat (10) @(negedge clk);
            access(24'h1234FF, 1'b1, 1'b1, 16'hBEEF, 1'b0);
            access(24'h1234FF, 1'b0, 1'b1, 16'h0000, 1'b1);
            for (int i = 0; i < 60; i++)
            begin
                r = $random(seed);
                r2 = $random(seed);
                access({r[23:16], 1'b0, r[14:0]}, r[31], r[30],
                       r2[15:0], r[29] & r[28]);
            end
        end
        hold_n = 1'b0;
        wait_ack(1'b1);
        check("hold_ack", 16'(ack), 16'h0001);
        repeat (20) @(negedge clk);
        check("hold_pins", 16'({ack, stb_n, ctl_oe, mid_oe, hi_oe}),
              16'h0018);
        hold_n = 1'b1;
        wait_ack(1'b0);
        check("hold_end", 16'(ack), 16'h0000);
        access(24'h0A0010, 1'b0, 1'b1, 16'h0000, 1'b0);
        end_sim;
    end

    initial
    begin
        #200000;
        n_mismatch++;
        end_sim;
    end
endmodule
